// [design/ddr_sched_pkg.sv]
// Shared constants for the inter-bank command scheduler pair.
// Assumes one 200 MHz clock for both ends of the command link.
package ddr_sched_pkg;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W    = 3;
	localparam int ADDR_W    = 14;
	localparam int AP_BIT    = 10;
	localparam int MR_W      = 4;

	// Command on {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_RD    = 4'h5;
	localparam logic [3:0] CMD_WR    = 4'h4;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_LM    = 4'h0;

	// Clock period in ps
	localparam int TCK_PS  = 5000;
	// Timing in ps and the derived cycle counts
	localparam int TRCD_PS = 15000;
	localparam int TRP_PS  = 15000;
	localparam int TWR_PS  = 15000;
	localparam int TWTR_PS = 7500;
	localparam int TMRD_CK = 2;
	localparam int TRCD_CK = (TRCD_PS + TCK_PS - 1) / TCK_PS;
	localparam int TRP_CK  = (TRP_PS + TCK_PS - 1) / TCK_PS;
	localparam int TWR_CK  = (TWR_PS + TCK_PS - 1) / TCK_PS;
	localparam int TWTR_RAW = (TWTR_PS + TCK_PS - 1) / TCK_PS;
	localparam int TWTR_CK = (TWTR_RAW > 2) ? TWTR_RAW : 2;

	localparam int CL_CK   = 4;
	localparam int BL      = 4;
	localparam int CNT_W   = 6;
	localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
endpackage

// [design/ddr_cmd_if.sv]
// Command pins between controller and DRAM bank model.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface ddr_cmd_if;
	import ddr_sched_pkg::*;
	logic              cke;
	logic              cs_n;
	logic              ras_n;
	logic              cas_n;
	logic              we_n;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;

	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
	modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface
`default_nettype wire

// [design/ddr_bank_ctrl.sv]
// Controller end: tracks every bank and spaces commands legally.
// Assumes user requests stay stable until accepted by req_ready_out.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Deselect ignores all other command pins
// - NOP keeps running operations going
// - Commands only with CKE high twice
// - Idle bank n leaves bank m free
// - Decode ACT, READ, WRITE, PRECHARGE encodings
// - Active or reading bank permits other commands
// - Writing bank permits others, honour turnaround
// - Write waits until other read finishes
// - Turnaround is max of two, tWTR
// - Refresh and load mode need idle banks
// - Never issue unlisted state/command pairs
// - Idle and active state definitions
// - Read auto precharge starts at earliest point
// - Write auto precharge starts after tWR
// - Other banks accepted during auto precharge
// - Delays after write with auto precharge
// - Delays after read with auto precharge
// - Load mode selects register by bank
// - Only NOP during tMRD after load mode
// - Activate opens row until precharge
// - Precharge before opening another row
// - Command sampled on rising clock edge
// - A10 selects auto precharge on access
module ddr_bank_ctrl
	import ddr_sched_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              req_valid_in,
	input  wire logic [3:0]        req_cmd_in,
	input  wire logic [BANK_W-1:0] req_bank_in,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	output logic                   req_ready_out,
	ddr_cmd_if.ctrl                cmd_if
);
	localparam int RD2WR = BL/2 + 2;
	localparam int WR2RD = (CL_CK - 1) + BL/2 + TWTR_CK;

	// ----------------------------------------
	// Bank tracking
	// ----------------------------------------
	logic [NUM_BANKS-1:0] open_q, open_d;
	logic [CNT_W-1:0]     busy_q [NUM_BANKS];
	logic [CNT_W-1:0]     busy_d [NUM_BANKS];
	logic [CNT_W-1:0]     rd_gap_q, rd_gap_d;
	logic [CNT_W-1:0]     wr_gap_q, wr_gap_d;
	logic [CNT_W-1:0]     any_gap_q, any_gap_d;
	logic                 cke_q, cke_d;
	logic                 legal;
	logic                 all_idle;
	logic                 fire;
	logic                 ap;

	// ----------------------------------------
	// Request legality
	// ----------------------------------------
	always_comb begin
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (open_q[i] || busy_q[i] != '0) begin
				all_idle = 1'b0;
			end
		end
		ap = req_addr_in[AP_BIT];
		legal = 1'b0;
		if (cke_q && any_gap_q == '0 && busy_q[req_bank_in] == '0) begin
			unique case (req_cmd_in)
				CMD_ACT: legal = !open_q[req_bank_in];
				CMD_RD:  legal = open_q[req_bank_in] && rd_gap_q == '0;
				CMD_WR:  legal = open_q[req_bank_in] && wr_gap_q == '0;
				CMD_PRE: legal = 1'b1;
				CMD_REF, CMD_LM: legal = all_idle && rd_gap_q == '0
					&& wr_gap_q == '0;
				default: legal = 1'b0;
			endcase
		end
		fire = req_valid_in && legal;
	end

	// ----------------------------------------
	// Next bank state
	// ----------------------------------------
	// Gaps load the full delay: one spare cycle buys a plain zero test
	always_comb begin
		open_d    = open_q;
		cke_d     = 1'b1;
		rd_gap_d  = (rd_gap_q != '0) ? rd_gap_q - 1'b1 : rd_gap_q;
		wr_gap_d  = (wr_gap_q != '0) ? wr_gap_q - 1'b1 : wr_gap_q;
		any_gap_d = (any_gap_q != '0) ? any_gap_q - 1'b1 : any_gap_q;
		for (int i = 0; i < NUM_BANKS; i++) begin
			busy_d[i] = (busy_q[i] != '0) ? busy_q[i] - 1'b1 : busy_q[i];
		end
		if (fire) begin
			unique case (req_cmd_in)
				CMD_ACT: begin
					open_d[req_bank_in] = 1'b1;
					busy_d[req_bank_in] = CNT_W'(TRCD_CK);
				end
				CMD_PRE: begin
					open_d[req_bank_in] = 1'b0;
					busy_d[req_bank_in] = CNT_W'(TRP_CK);
				end
				CMD_RD: begin
					rd_gap_d = CNT_W'(BL/2);
					wr_gap_d = CNT_W'(RD2WR);
					// auto precharge after burst
					// Busy covers tRP too, so no ACT beats the internal precharge
					if (ap) begin
						open_d[req_bank_in] = 1'b0;
						busy_d[req_bank_in] = CNT_W'(BL/2 + TRP_CK);
					end
				end
				CMD_WR: begin
					rd_gap_d = CNT_W'(WR2RD);
					wr_gap_d = CNT_W'(BL/2);
					if (ap) begin
						open_d[req_bank_in] = 1'b0;
						busy_d[req_bank_in] =
							CNT_W'(CL_CK - 1 + BL/2 + TWR_CK + TRP_CK);
					end
				end
				CMD_LM: any_gap_d = CNT_W'(TMRD_CK);
				default: any_gap_d = any_gap_q;
			endcase
		end
	end

	// ----------------------------------------
	// Bank registers
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			open_q    <= '0;
			rd_gap_q  <= '0;
			wr_gap_q  <= '0;
			any_gap_q <= '0;
			cke_q     <= 1'b0;
			for (int i = 0; i < NUM_BANKS; i++) begin
				busy_q[i] <= '0;
			end
		end else begin
			open_q    <= open_d;
			rd_gap_q  <= rd_gap_d;
			wr_gap_q  <= wr_gap_d;
			any_gap_q <= any_gap_d;
			cke_q     <= cke_d;
			for (int i = 0; i < NUM_BANKS; i++) begin
				busy_q[i] <= busy_d[i];
			end
		end
	end

	// ----------------------------------------
	// Command pins
	// ----------------------------------------
	logic [3:0]        pins_q, pins_d;
	logic [BANK_W-1:0] ba_q, ba_d;
	logic [ADDR_W-1:0] addr_q, addr_d;

	always_comb begin
		pins_d = fire ? req_cmd_in : CMD_NOP;
		ba_d   = fire ? req_bank_in : ba_q;
		addr_d = fire ? req_addr_in : addr_q;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pins_q <= CMD_NOP;
			ba_q   <= '0;
			addr_q <= '0;
		end else begin
			pins_q <= pins_d;
			ba_q   <= ba_d;
			addr_q <= addr_d;
		end
	end

	// CKE rises one cycle before commands so it was high on the prior edge
	assign req_ready_out = fire;
	assign cmd_if.cke    = cke_q;
	assign cmd_if.cs_n   = pins_q[3];
	assign cmd_if.ras_n  = pins_q[2];
	assign cmd_if.cas_n  = pins_q[1];
	assign cmd_if.we_n   = pins_q[0];
	assign cmd_if.ba     = ba_q;
	assign cmd_if.addr   = addr_q;
endmodule
`default_nettype wire

// [design/ddr_bank_mem.sv]
// Device end: decodes commands and keeps per-bank row and precharge state.
// Assumes command pins are driven on the same clock by the controller.
`timescale 1ns/1ps
`default_nettype none

module ddr_bank_mem
	import ddr_sched_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	ddr_cmd_if.mem                 cmd_if,
	output logic [NUM_BANKS-1:0]   bank_open_out,
	output logic [NUM_BANKS-1:0]   bank_idle_out,
	output logic [ADDR_W-1:0]      mode_reg_out [MR_W],
	output logic                   cmd_seen_out
);
	logic [NUM_BANKS-1:0] open_q, open_d;
	logic [ADDR_W-1:0]    row_q [NUM_BANKS];
	logic [ADDR_W-1:0]    row_d [NUM_BANKS];
	logic [CNT_W-1:0]     ap_q [NUM_BANKS];
	logic [CNT_W-1:0]     ap_d [NUM_BANKS];
	logic [CNT_W-1:0]     rp_q [NUM_BANKS];
	logic [CNT_W-1:0]     rp_d [NUM_BANKS];
	logic [ADDR_W-1:0]    mr_q [MR_W];
	logic [ADDR_W-1:0]    mr_d [MR_W];
	logic                 cke_prev_q;
	logic                 seen_q, seen_d;
	logic [3:0]           cmd;
	logic                 valid;

	always_comb begin
		cmd = {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n};
		valid = cmd_if.cke && cke_prev_q && !cmd_if.cs_n && cmd != CMD_NOP;
		open_d = open_q;
		seen_d = valid;
		for (int i = 0; i < NUM_BANKS; i++) begin
			row_d[i] = row_q[i];
			ap_d[i]  = ap_q[i];
			rp_d[i]  = (rp_q[i] != '0) ? rp_q[i] - 1'b1 : rp_q[i];
			if (ap_q[i] != '0) begin
				ap_d[i] = ap_q[i] - 1'b1;
				if (ap_q[i] == CNT_W'(1)) begin
					open_d[i] = 1'b0;
					rp_d[i]   = CNT_W'(TRP_CK);
				end
			end
		end
		for (int i = 0; i < MR_W; i++) begin
			mr_d[i] = mr_q[i];
		end
		// only the bank named on ba takes the command
		if (valid) begin
			unique case (cmd)
				CMD_ACT: begin
					open_d[cmd_if.ba] = 1'b1;
					row_d[cmd_if.ba]  = cmd_if.addr;
				end
				CMD_PRE: begin
					open_d[cmd_if.ba] = 1'b0;
					ap_d[cmd_if.ba]   = '0;
					rp_d[cmd_if.ba]   = CNT_W'(TRP_CK);
				end
				CMD_RD: begin
					if (cmd_if.addr[AP_BIT]) begin
						ap_d[cmd_if.ba] = CNT_W'(BL/2);
					end
				end
				CMD_WR: begin
					if (cmd_if.addr[AP_BIT]) begin
						ap_d[cmd_if.ba] = CNT_W'(CL_CK - 1 + BL/2 + TWR_CK);
					end
				end
				CMD_LM: begin
					if (int'(cmd_if.ba) < MR_W) begin
						mr_d[cmd_if.ba[1:0]] = cmd_if.addr;
					end
				end
				default: seen_d = valid;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			open_q     <= '0;
			cke_prev_q <= 1'b0;
			seen_q     <= 1'b0;
			for (int i = 0; i < NUM_BANKS; i++) begin
				row_q[i] <= '0;
				ap_q[i]  <= '0;
				rp_q[i]  <= '0;
			end
			for (int i = 0; i < MR_W; i++) begin
				mr_q[i] <= MR_RESET;
			end
		end else begin
			open_q     <= open_d;
			cke_prev_q <= cmd_if.cke;
			seen_q     <= seen_d;
			row_q      <= row_d;
			ap_q       <= ap_d;
			rp_q       <= rp_d;
			mr_q       <= mr_d;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_BANKS; i++) begin
			// idle only once tRP has run out
			bank_idle_out[i] = !open_q[i] && ap_q[i] == '0 && rp_q[i] == '0;
		end
	end
	assign bank_open_out = open_q;
	assign mode_reg_out  = mr_q;
	assign cmd_seen_out  = seen_q;
endmodule
`default_nettype wire

// [tb/ddr_sched_props.sv]
// Checker on the command pins between controller and bank model.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module ddr_sched_props
	import ddr_sched_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	input wire logic              cke_in,
	input wire logic              cs_n_in,
	input wire logic              ras_n_in,
	input wire logic              cas_n_in,
	input wire logic              we_n_in,
	input wire logic [BANK_W-1:0] ba_in,
	input wire logic [ADDR_W-1:0] addr_in
);
	logic [3:0] cmd;
	logic       rw;
	assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
	assign rw = (cmd == CMD_RD) || (cmd == CMD_WR);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------
	// Spacing on the wire
	// ----------------------------------------
	a_exec_cke_two: assert property (!cs_n_in && cmd != CMD_NOP
		|-> cke_in && $past(cke_in))
		else $error("command without cke high twice");
	a_wr_rd_gap: assert property (cmd == CMD_WR |=> (cmd != CMD_RD) [*6])
		else $error("write to read too close");
	a_rd_wr_gap: assert property (cmd == CMD_RD |=> (cmd != CMD_WR) [*3])
		else $error("read to write too close");
	a_rd_rd_gap: assert property (cmd == CMD_RD |=> cmd != CMD_RD)
		else $error("read to read too close");
	a_wr_wr_gap: assert property (cmd == CMD_WR |=> cmd != CMD_WR)
		else $error("write to write too close");
	a_lm_quiet: assert property (cmd == CMD_LM |=> cs_n_in || cmd == CMD_NOP)
		else $error("command inside mode delay");
	a_act_rcd_met: assert property (rw |->
		!($past(cmd) == CMD_ACT && $past(ba_in) == ba_in)
		&& !($past(cmd, 2) == CMD_ACT && $past(ba_in, 2) == ba_in))
		else $error("access before row ready");
	a_pre_rp_met: assert property (cmd == CMD_ACT |->
		!($past(cmd) == CMD_PRE && $past(ba_in) == ba_in)
		&& !($past(cmd, 2) == CMD_PRE && $past(ba_in, 2) == ba_in))
		else $error("activate before precharge done");
	a_ap_no_reuse: assert property (rw && addr_in[AP_BIT]
		|=> !(rw && ba_in == $past(ba_in)))
		else $error("access to a bank closing by auto precharge");
endmodule
`default_nettype wire

// [tb/ddr2_interbank_command_scheduling_tb_top.sv]
// Bench joining controller and bank model through the command link.
// Assumes package timing; only user requests are driven here.
`timescale 1ns/1ps
`default_nettype none
module ddr2_interbank_command_scheduling_tb_top;
	import ddr_sched_pkg::*;
	logic                 clk_in = 1'b0;
	logic                 sys_rst_in = 1'b1;
	logic                 vld = 1'b0;
	logic [3:0]           rcmd = CMD_NOP;
	logic [BANK_W-1:0]    rbank = 3'h0;
	logic [ADDR_W-1:0]    raddr = 14'h0000;
	logic                 rdy;
	logic [NUM_BANKS-1:0] opn;
	logic [NUM_BANKS-1:0] idl;
	logic [ADDR_W-1:0]    mr [MR_W];
	logic                 seen;
	int                   n_seen = 0;
	int                   n_fail = 0;
	int                   compares = 0;

	always #2.5 clk_in = ~clk_in;

	// Counts commands the bank end actually executed
	always @(posedge clk_in) begin
		if (seen === 1'b1) begin
			n_seen <= n_seen + 1;
		end
	end

	ddr_cmd_if ddr_cmd_if_i ();
	ddr_bank_ctrl ddr_bank_ctrl_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.req_valid_in(vld), .req_cmd_in(rcmd), .req_bank_in(rbank),
		.req_addr_in(raddr), .req_ready_out(rdy), .cmd_if(ddr_cmd_if_i));
	ddr_bank_mem ddr_bank_mem_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.cmd_if(ddr_cmd_if_i), .bank_open_out(opn), .bank_idle_out(idl),
		.mode_reg_out(mr), .cmd_seen_out(seen));
	ddr_sched_props ddr_sched_props_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.cke_in(ddr_cmd_if_i.cke), .cs_n_in(ddr_cmd_if_i.cs_n),
		.ras_n_in(ddr_cmd_if_i.ras_n), .cas_n_in(ddr_cmd_if_i.cas_n),
		.we_n_in(ddr_cmd_if_i.we_n), .ba_in(ddr_cmd_if_i.ba),
		.addr_in(ddr_cmd_if_i.addr));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Holds the request until ready is seen, or gives up after 30 cycles
	task automatic req(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic e);
		logic acc;
		acc = 1'b0;
		@(posedge clk_in);
		vld <= 1'b1;
		rcmd <= c;
		rbank <= b;
		raddr <= a;
		repeat (30) begin
			@(negedge clk_in);
			if (rdy === 1'b1) begin
				acc = 1'b1;
				break;
			end
		end
		@(posedge clk_in);
		vld <= 1'b0;
		chk(16'(acc), 16'(e));
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic stop_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		wt(2);
		chk(16'(idl), 16'h00ff);
		chk(16'(opn), 16'h0000);
		chk(16'(mr[1]), 16'h0000);
		$display("reset test done");
		req(CMD_LM, 3'h1, 14'h0123, 1'b1);
		req(CMD_ACT, 3'h0, 14'h0005, 1'b1);
		wt(4);
		chk(16'(mr[1]), 16'h0123);
		chk(16'(opn), 16'h0001);
		$display("mode test done");
		req(CMD_ACT, 3'h1, 14'h0011, 1'b1);
		req(CMD_ACT, 3'h2, 14'h0022, 1'b1);
		req(CMD_RD, 3'h0, 14'h0400, 1'b1);
		req(CMD_WR, 3'h1, 14'h0400, 1'b1);
		req(CMD_RD, 3'h2, 14'h0000, 1'b1);
		wt(20);
		chk(16'(opn), 16'h0004);
		chk(16'(idl), 16'h00fb);
		$display("auto precharge test done");
		req(CMD_RD, 3'h3, 14'h0000, 1'b0);
		req(CMD_REF, 3'h0, 14'h0000, 1'b0);
		req(CMD_ACT, 3'h2, 14'h0009, 1'b0);
		req(4'hf, 3'h0, 14'h0000, 1'b0);
		$display("refusal test done");
		req(CMD_PRE, 3'h2, 14'h0000, 1'b1);
		req(CMD_ACT, 3'h2, 14'h0009, 1'b1);
		req(CMD_PRE, 3'h2, 14'h0000, 1'b1);
		req(CMD_REF, 3'h0, 14'h0000, 1'b1);
		wt(20);
		chk(16'(idl), 16'h00ff);
		chk(16'(n_seen), 16'h000b);
		$display("reopen test done");
		stop_test();
	end

	initial begin
		repeat (3000) @(posedge clk_in);
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire
